// >>> hw/wdt_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the watchdog
// Assumes: 32-bit avalon word addressing by byte address
// Notes:   definitions only
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define WDT_OFS_CTRL    6'h00
`define WDT_OFS_RESTART 6'h04
`define WDT_OFS_STATUS  6'h08
`define WDT_OFS_MASK    6'h0c
`define WDT_OFS_COUNT   6'h10
`define WDT_OFS_ID      6'h14

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define WDT_CTRL_EN_BIT    0
`define WDT_CTRL_LOCK_BIT  1
`define WDT_CTRL_SEL_LSB   4
`define WDT_CTRL_SEL_MSB   7

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define WDT_ST_FLAG_BIT    0
`define WDT_ST_RESET_BIT   1

// ----------------------------------------------------------------------------
// keys, reset values and timing
// ----------------------------------------------------------------------------
`define WDT_RESTART_KEY    32'h0000_5a5a
`define WDT_MIN_EXP        16
`define WDT_SEL_RST        4'hf
`define WDT_MASK_RST       2'h3
`define WDT_RESET_CYCLES   8'h10

`endif

// >>> hw/wdt_pkg.sv
// Purpose: types shared by the watchdog
// Assumes: nothing
// Notes:   escalation state is one-hot
package wdt_pkg;

  typedef enum logic [1:0] {
    WDT_ARMED   = 2'b01,
    WDT_WARNED  = 2'b10
  } wdt_stage_type;

endpackage

// >>> hw/wdt_top.sv
// Purpose: two-stage watchdog with avalon-mm register slave
// Assumes: single 250 MHz clock, software as the only party
// Notes:   chip reset request is a pulse stretched to a fixed length
//
// Overview of operation
// - the counter advances on every system clock while enabled and needs no other timing source.
// - sixteen time-outs are selectable, two to the power 16 through 31 clock cycles.
// - reaching the time-out without a restart while the status flag is clear raises the fast interrupt request.
// - the first expiry raises the fast interrupt and sets the interrupt status flag.
// - an expiry while the status flag is still set asserts a chip reset instead.
// - every expiry gives either a fast interrupt or a chip reset, chosen by the escalation stage and the status flag.
// - enable, lockout and a keyed restart protect the watchdog against stray writes.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps

`include "wdt_cfg.svh"

module wdt_top
  import wdt_pkg::*;
#(
  parameter int          CNT_W    = 32,
  parameter int          MIN_EXP  = `WDT_MIN_EXP,  // exponent of the shortest time-out
  parameter int          N_SEL    = 16,            // number of selectable time-outs
  parameter logic [31:0] ID_VALUE = 32'h0000_0a01  // arbitrary identification value
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             fast_interrupt_request,
  output logic             irq,
  output logic             chip_reset_req
);

  // --------------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------------
  logic             rd_done_r;
  logic [31:0]      avs_readdata_r;
  logic             enable_r;
  logic             lock_r;
  logic [3:0]       sel_r;
  logic [1:0]       status_r;
  logic [1:0]       mask_r;
  logic [CNT_W-1:0] count_r;
  wdt_stage_type    stage_r;
  logic [7:0]       rst_cnt_r;
  logic             wr_en;
  logic             restart;
  logic             expire;
  logic [1:0]       st_set;
  logic [1:0]       st_clr;
  logic             escalate;
  logic [N_SEL-1:0] tc_hit;

  // writes finish at once; reads take one wait cycle so data come from a flop
  assign avs_waitrequest = avs_read & ~rd_done_r;
  assign avs_readdata    = avs_readdata_r;
  assign wr_en           = avs_write & avs_byteenable[0];

  function automatic logic hit(input logic [5:0] adr, input logic [5:0] ofs);
    hit = (adr == ofs);
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= avs_read & ~rd_done_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata_r <= 32'h0000_0000;
    end else if (avs_read & ~rd_done_r) begin
      avs_readdata_r <= 32'h0000_0000;
      if (hit(avs_address, `WDT_OFS_CTRL)) begin
        avs_readdata_r[`WDT_CTRL_EN_BIT]                    <= enable_r;
        avs_readdata_r[`WDT_CTRL_LOCK_BIT]                  <= lock_r;
        avs_readdata_r[`WDT_CTRL_SEL_MSB:`WDT_CTRL_SEL_LSB] <= sel_r;
      end else if (hit(avs_address, `WDT_OFS_STATUS)) begin
        avs_readdata_r[1:0] <= status_r;
      end else if (hit(avs_address, `WDT_OFS_MASK)) begin
        avs_readdata_r[1:0] <= mask_r;
      end else if (hit(avs_address, `WDT_OFS_COUNT)) begin
        avs_readdata_r <= 32'(count_r);
      end else if (hit(avs_address, `WDT_OFS_ID)) begin
        avs_readdata_r <= ID_VALUE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control: enable, lockout and time-out select
  // --------------------------------------------------------------------------
  // once locked only reset reopens the control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_r <= 1'b0;
      lock_r   <= 1'b0;
      sel_r    <= `WDT_SEL_RST;
    end else if (wr_en && hit(avs_address, `WDT_OFS_CTRL) && !lock_r) begin
      enable_r <= avs_writedata[`WDT_CTRL_EN_BIT];
      lock_r   <= avs_writedata[`WDT_CTRL_LOCK_BIT];
      sel_r    <= avs_writedata[`WDT_CTRL_SEL_MSB:`WDT_CTRL_SEL_LSB];
    end
  end

  // restart only with the full key in one word, so a stray byte write cannot feed it
  assign restart = avs_write && (avs_byteenable == 4'hf) && hit(avs_address, `WDT_OFS_RESTART)
                   && (avs_writedata == `WDT_RESTART_KEY);

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  // ----------------------------------------------------------------------------
  // terminal counts
  // ----------------------------------------------------------------------------
  // one compare per selectable length; the select only picks a result, so a
  // change of select never needs a wide shifter in the count path
  function automatic logic [CNT_W-1:0] last_count(input int exp_val);
    last_count = CNT_W'((64'h1 << exp_val) - 64'h1);
  endfunction

  for (genvar g = 0; g < N_SEL; g++) begin : g_tc
    assign tc_hit[g] = (count_r == last_count(MIN_EXP + g));
  end

  // counter starts over after each expiry
  assign expire = enable_r && tc_hit[sel_r];

  // the second stage only escalates while the flag from the first still stands
  assign escalate = expire && (stage_r == WDT_WARNED) && status_r[`WDT_ST_FLAG_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (restart || expire || !enable_r) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  // --------------------------------------------------------------------------
  // escalation
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r <= WDT_ARMED;
    end else begin
      case (stage_r)
        WDT_ARMED: begin
          if (expire) begin
            stage_r <= WDT_WARNED;
          end
        end
        WDT_WARNED: begin
          if (!status_r[`WDT_ST_FLAG_BIT] && !expire) begin
            stage_r <= WDT_ARMED;
          end
        end
        default: begin
          stage_r <= WDT_ARMED;
        end
      endcase
    end
  end

  // the reset request is stretched so the chip reset logic surely sees it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_cnt_r <= 8'h00;
    end else if (escalate) begin
      rst_cnt_r <= `WDT_RESET_CYCLES;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= escalate || (rst_cnt_r > 8'h01);
    end
  end

  // --------------------------------------------------------------------------
  // status, mask and interrupt
  // --------------------------------------------------------------------------
  assign st_set = {escalate, expire & ~escalate};
  assign st_clr = (wr_en && hit(avs_address, `WDT_OFS_STATUS)) ? avs_writedata[1:0] : 2'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= 2'h0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_r <= `WDT_MASK_RST;
    end else if (wr_en && hit(avs_address, `WDT_OFS_MASK)) begin
      mask_r <= avs_writedata[1:0];
    end
  end

  // fast interrupt follows the flag; it is not maskable so a hung handler still escalates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fast_interrupt_request <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      fast_interrupt_request <= status_r[`WDT_ST_FLAG_BIT] | st_set[`WDT_ST_FLAG_BIT];
      irq                    <= |(((status_r & ~st_clr) | st_set) & mask_r);
    end
  end

endmodule

// >>> testbench/wdt_checker_sva.sv
// Purpose: port checker for the watchdog
// Assumes: master releases a read for one cycle after its answer
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module wdt_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        fast_interrupt_request,
  input wire logic        chip_reset_req
);
  logic [4:0] hi_r;
  // counts the reset pulse; a stuck pulse wraps, but then it never falls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hi_r <= 5'h00;
    else hi_r <= chip_reset_req ? hi_r + 5'h01 : 5'h00;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read too slow");
  a_read_wait_first: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest) else $error("no wait");
  a_rdata_stands: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("read data moved");
  a_reset_pulse_len: assert property ($fell(chip_reset_req) |-> hi_r == 5'h10) else $error("reset length");
  a_reset_needs_flag: assert property ($rose(chip_reset_req) |-> $past(fast_interrupt_request))
    else $error("reset without flag");
  a_first_no_reset: assert property ($rose(fast_interrupt_request) |-> !chip_reset_req) else $error("early reset");
  a_flag_sticky: assert property ($fell(fast_interrupt_request) |-> $past(avs_write, 2)) else $error("flag lost");
endmodule

// >>> testbench/wdt_top_bench.sv
// Purpose: self-checking bench for the watchdog
// Assumes: shortest exponent lowered to 8 for the run, so one time-out is 256 cycles
// Notes:   byteenable tied to all lanes
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module wdt_top_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        fast_interrupt_request;
  logic        irq;
  logic        chip_reset_req;
  logic [31:0] d;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t0;
  localparam int TB_EXP = 8;
  localparam int TB_N   = 1 << TB_EXP;
  always #2 clock = ~clock;
  wdt_top #(.MIN_EXP(TB_EXP)) dut_u (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_interrupt_request(fast_interrupt_request), .irq(irq), .chip_reset_req(chip_reset_req));
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is sampled low; a hang is cut by the timeout
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, d);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rchk("ctrl", `WDT_OFS_CTRL, 32'h0000_00f0);
    rchk("mask", `WDT_OFS_MASK, 32'h0000_0003);
    rchk("unmapped", 6'h18, 32'h0000_0000);
    bus(1'b1, `WDT_OFS_CTRL, 32'h0000_0001);
    bus(1'b1, `WDT_OFS_RESTART, `WDT_RESTART_KEY);
    @(negedge clock);
    t0 = cyc;
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk("count_cleared", 32'h1, {31'h0, d < 32'h8});
    bus(1'b1, `WDT_OFS_RESTART, 32'h0000_1234);
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk("bad_key_ignored", 32'h1, {31'h0, d >= 32'h5});
    while (fast_interrupt_request !== 1'b1) @(negedge clock);
    chk("expiry_time", 32'h1, {31'h0, (cyc - t0) >= TB_N && (cyc - t0) <= TB_N + 2});
    t0 = cyc;
    chk("no_reset", 32'h0, {31'h0, chip_reset_req});
    chk("irq", 32'h1, {31'h0, irq});
    rchk("status", `WDT_OFS_STATUS, 32'h0000_0001);
    bus(1'b1, `WDT_OFS_MASK, 32'h0);
    repeat (2) @(negedge clock);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, `WDT_OFS_MASK, 32'h3);
    bus(1'b1, `WDT_OFS_CTRL, 32'h0000_0003);
    bus(1'b1, `WDT_OFS_CTRL, 32'h0000_0000);
    rchk("ctrl_locked", `WDT_OFS_CTRL, 32'h0000_0003);
    while (chip_reset_req !== 1'b1) @(negedge clock);
    chk("escalation_time", 32'h1, {31'h0, (cyc - t0) == TB_N});
    rchk("status_both", `WDT_OFS_STATUS, 32'h0000_0003);
    bus(1'b1, `WDT_OFS_STATUS, 32'h0000_0003);
    rchk("status_clear", `WDT_OFS_STATUS, 32'h0000_0000);
    repeat (20) @(negedge clock);
    chk("flag_low", 32'h0, {31'h0, fast_interrupt_request});
    finish_test();
  end
endmodule
bind wdt_top wdt_checker chk_u (.clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .fast_interrupt_request(fast_interrupt_request), .chip_reset_req(chip_reset_req));
